//--- logic/ampp_map.vh
// Constants for the macroblock payload parser: offsets, fields, codes
`ifndef AMPP_MAP_VH
`define AMPP_MAP_VH
// Register byte offsets
`define AMPP_OFS_CTRL 8'h00
`define AMPP_OFS_STATUS 8'h04
`define AMPP_OFS_FLAGS 8'h08
`define AMPP_OFS_ORIGIN 8'h0C
`define AMPP_OFS_PATTERN 8'h10
`define AMPP_OFS_COUNT 8'h14
// Control fields and reset value
`define AMPP_CTRL_EN 0
`define AMPP_CTRL_MC 1
`define AMPP_CTRL_RST 2'h3
// Status sticky error bits
`define AMPP_ST_FMT 0
`define AMPP_ST_COEF 1
// Command layout
`define AMPP_INLINE_START 8'h04
`define AMPP_IT_WORDS 8'h03
`define AMPP_REG_WORDS_LOG2 3
// Inline word 0 fields
`define AMPP_ADAPT_HI 26
`define AMPP_ADAPT_LO 25
`define AMPP_POL 24
`define AMPP_MV_HI 22
`define AMPP_MV_LO 20
`define AMPP_LARGE 15
`define AMPP_FIELDMB 14
`define AMPP_INTRA 13
`define AMPP_KIND_HI 12
`define AMPP_KIND_LO 8
`define AMPP_BIDIR_HI 7
`define AMPP_BIDIR_LO 6
`define AMPP_CHROMA_HI 3
`define AMPP_CHROMA_LO 2
`define AMPP_AFP 1
`define AMPP_FP 0
// Inline word 2 presence field
`define AMPP_PRES_HI 13
`define AMPP_PRES_LO 8
// Coefficient record fields
`define AMPP_CVAL_HI 31
`define AMPP_CVAL_LO 16
`define AMPP_CRSV_HI 15
`define AMPP_CRSV_LO 7
`define AMPP_CIDX_HI 6
`define AMPP_CIDX_LO 1
`define AMPP_CLAST 0
// Codes
`define AMPP_MV_ONE_PAIR 3'h2
`define AMPP_BIDIR_IMPLICIT 2'h2
`define AMPP_KIND_L0 5'h01
`define AMPP_KIND_L1 5'h02
`define AMPP_BLK_DONE 3'h6
`endif

//--- logic/ampp_parser.v
// Macroblock command and coefficient parser with Wishbone registers
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ampp_map.vh"
module ampp_parser (
    input wire CLK,
    input wire NRST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [7:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    input wire CMD_VALID,
    input wire [31:0] CMD_DATA,
    input wire CMD_LAST,
    output reg CMD_READY,
    output reg PAY_VALID,
    output reg [31:0] PAY_DATA,
    output reg PAY_LAST,
    input wire PAY_READY,
    input wire IND_VALID,
    input wire [31:0] IND_DATA,
    input wire IND_WEIGHT,
    output reg IND_READY,
    output reg OUT_VALID,
    output reg OUT_WEIGHT,
    output reg [31:0] OUT_DATA,
    output reg [15:0] COEF_VALUE,
    output reg [5:0] COEF_INDEX,
    output reg COEF_LAST,
    output reg [2:0] COEF_BLOCK,
    output reg [1:0] COEF_SUB,
    input wire OUT_READY
);

// ----------------------------------------
// Local states and functions
// ----------------------------------------
localparam ST_HDR = 2'b00;
localparam ST_INL = 2'b01;
localparam ST_FILL = 2'b10;

// Lowest present block at or after start, else done
function [2:0] next_blk;
    input [5:0] pres;
    input [2:0] start;
    integer i;
    begin
        next_blk = `AMPP_BLK_DONE;
        for (i = 5; i >= 0; i = i - 1) begin
            if (pres[5 - i] && (i >= start)) begin
                next_blk = i[2:0];
            end
        end
    end
endfunction

// Reserved codes and illegal combinations in inline word 0
function fmt_bad;
    input [31:0] w;
    reg [2:0] mv;
    reg adapt;
    begin
        mv = w[`AMPP_MV_HI:`AMPP_MV_LO];
        adapt = w[`AMPP_AFP] & w[`AMPP_FIELDMB];
        fmt_bad = 1'b0;
        if (w[`AMPP_ADAPT_HI:`AMPP_ADAPT_LO] != {2{adapt}}) fmt_bad = 1'b1;
        if (!w[`AMPP_FP] && !w[`AMPP_AFP] && w[`AMPP_POL]) fmt_bad = 1'b1;
        if (mv == 3'h1 || mv == 3'h3 || mv == 3'h7) fmt_bad = 1'b1;
        if (w[`AMPP_INTRA] && mv != 3'h0) fmt_bad = 1'b1;
        if (w[`AMPP_CHROMA_HI]) fmt_bad = 1'b1;
        if (w[`AMPP_FP] && w[`AMPP_AFP]) fmt_bad = 1'b1;
        if (!w[`AMPP_INTRA] && w[`AMPP_BIDIR_HI:`AMPP_BIDIR_LO] == 2'h3)
            fmt_bad = 1'b1;
    end
endfunction

// ----------------------------------------
// Registers
// ----------------------------------------
reg [1:0] ctrl_ff;
reg [1:0] err_ff;
reg [31:0] inl0_ff;
reg [31:0] inl1_ff;
reg [31:0] inl2_ff;
reg [15:0] ccnt_ff;
reg [1:0] state_ff;
reg [7:0] wcnt_ff;
reg [2:0] pcnt_ff;
reg [5:0] pres_ff;
reg [2:0] blk_ff;
reg [1:0] sub_ff;

reg [1:0] nxt_state;
reg [7:0] nxt_wcnt;
reg [2:0] nxt_pcnt;
reg nxt_pay_vld;
reg [31:0] nxt_pay_data;
reg nxt_pay_last;
reg pay_load;
reg [1:0] err_set;
reg [1:0] err_clr;

wire en = ctrl_ff[`AMPP_CTRL_EN];
wire mc_mode = ctrl_ff[`AMPP_CTRL_MC];
wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
wire cmd_take = CMD_VALID & CMD_READY;
wire ind_take = IND_VALID & IND_READY;
wire pay_free = ~PAY_VALID | PAY_READY;
wire [7:0] inl_idx = wcnt_ff - `AMPP_INLINE_START;
wire inl_keep = mc_mode | (inl_idx < `AMPP_IT_WORDS);

// ----------------------------------------
// Wishbone slave
// ----------------------------------------
// One-cycle ack; writes and read data taken on the request edge
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        WB_ACK_O <= 1'b0;
        WB_DAT_O <= 32'h00000000;
        ctrl_ff <= `AMPP_CTRL_RST;
    end else begin
        WB_ACK_O <= wb_req;
        if (wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `AMPP_OFS_CTRL) begin
            ctrl_ff <= WB_DAT_I[1:0];
        end
        if (wb_req) begin
            case (WB_ADR_I)
                `AMPP_OFS_CTRL: WB_DAT_O <= {30'h0, ctrl_ff};
                `AMPP_OFS_STATUS: WB_DAT_O <= {21'h0, blk_ff, sub_ff, 2'h0, state_ff, err_ff};
                `AMPP_OFS_FLAGS: WB_DAT_O <= inl0_ff;
                `AMPP_OFS_ORIGIN: WB_DAT_O <= {16'h0, inl1_ff[15:0]};
                `AMPP_OFS_PATTERN: WB_DAT_O <= {26'h0, pres_ff};
                `AMPP_OFS_COUNT: WB_DAT_O <= {16'h0, ccnt_ff};
                default: WB_DAT_O <= 32'h00000000;
            endcase
        end
    end
end

// Write-one-to-clear of sticky errors
always @* begin
    err_clr = 2'h0;
    if (wb_req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == `AMPP_OFS_STATUS) begin
        err_clr = WB_DAT_I[1:0];
    end
end

// Sticky errors, a new event beats a clear
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        err_ff <= 2'h0;
    end else begin
        err_ff <= (err_ff & ~err_clr) | err_set;
    end
end

// ----------------------------------------
// Command walker and payload forwarding
// ----------------------------------------
// Skip header, forward inline, zero-fill to register boundary
always @* begin
    nxt_state = state_ff;
    nxt_wcnt = wcnt_ff;
    nxt_pcnt = pcnt_ff;
    nxt_pay_vld = PAY_VALID & ~PAY_READY;
    nxt_pay_data = PAY_DATA;
    nxt_pay_last = PAY_LAST;
    pay_load = 1'b0;
    case (state_ff)
        ST_HDR: begin
            if (cmd_take) begin
                nxt_wcnt = wcnt_ff + 8'h01;
                if (CMD_LAST) begin
                    nxt_wcnt = 8'h00;
                end else if (wcnt_ff == `AMPP_INLINE_START - 8'h01) begin
                    nxt_state = ST_INL;
                end
            end
        end
        ST_INL: begin
            if (cmd_take) begin
                nxt_wcnt = wcnt_ff + 8'h01;
                if (inl_keep) begin
                    pay_load = 1'b1;
                    nxt_pcnt = pcnt_ff + 3'h1;
                end
                if (CMD_LAST) begin
                    nxt_wcnt = 8'h00;
                    nxt_state = (nxt_pcnt == 3'h0) ? ST_HDR : ST_FILL;
                end
            end
        end
        ST_FILL: begin
            if (pay_free) begin
                nxt_pcnt = pcnt_ff + 3'h1;
                nxt_pay_vld = 1'b1;
                nxt_pay_data = 32'h00000000;
                nxt_pay_last = (nxt_pcnt == 3'h0);
                if (nxt_pcnt == 3'h0) begin
                    nxt_state = ST_HDR;
                end
            end
        end
        default: begin
            nxt_state = ST_HDR;
        end
    endcase
    if (pay_load) begin
        nxt_pay_vld = 1'b1;
        nxt_pay_data = CMD_DATA;
        nxt_pay_last = CMD_LAST && (nxt_pcnt == 3'h0);
    end
end

// Walker registers; ready only when the payload slot will be empty
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        state_ff <= ST_HDR;
        wcnt_ff <= 8'h00;
        pcnt_ff <= 3'h0;
        PAY_VALID <= 1'b0;
        PAY_DATA <= 32'h00000000;
        PAY_LAST <= 1'b0;
        CMD_READY <= 1'b0;
    end else begin
        state_ff <= nxt_state;
        wcnt_ff <= nxt_wcnt;
        pcnt_ff <= nxt_pcnt;
        PAY_VALID <= nxt_pay_vld;
        PAY_DATA <= nxt_pay_data;
        PAY_LAST <= nxt_pay_last;
        CMD_READY <= en & (nxt_state != ST_FILL) & ~nxt_pay_vld;
    end
end

// Capture of the first three inline words for decode
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        inl0_ff <= 32'h00000000;
        inl1_ff <= 32'h00000000;
        inl2_ff <= 32'h00000000;
    end else if (state_ff == ST_INL && cmd_take) begin
        if (inl_idx == 8'h00) inl0_ff <= CMD_DATA;
        if (inl_idx == 8'h01) inl1_ff <= CMD_DATA;
        if (inl_idx == 8'h02) inl2_ff <= CMD_DATA;
    end
end

// ----------------------------------------
// Indirect data: weights and coefficient records
// ----------------------------------------
wire [15:0] w_lo = IND_DATA[15:0];
wire [15:0] w_hi = IND_DATA[31:16];
wire [4:0] mb_kind = inl0_ff[`AMPP_KIND_HI:`AMPP_KIND_LO];
wire mb_inter = ~inl0_ff[`AMPP_INTRA];
wire implicit_two = mb_inter &
    (inl0_ff[`AMPP_BIDIR_HI:`AMPP_BIDIR_LO] == `AMPP_BIDIR_IMPLICIT) &
    (inl0_ff[`AMPP_MV_HI:`AMPP_MV_LO] == `AMPP_MV_ONE_PAIR);
wire luma_large = inl0_ff[`AMPP_LARGE];
wire has_chroma = (inl0_ff[`AMPP_CHROMA_HI:`AMPP_CHROMA_LO] != 2'h0);
wire [1:0] sub_top = (blk_ff < 3'h4 && luma_large) ? 2'h0 : 2'h3;
wire mb_start = (state_ff == ST_INL) && cmd_take && (inl_idx == 8'h02);
wire [5:0] pres_new = CMD_DATA[`AMPP_PRES_HI:`AMPP_PRES_LO] & {4'hF, {2{has_chroma}}};
wire out_free = ~OUT_VALID | OUT_READY;
wire coef_take = ind_take & ~IND_WEIGHT;
reg [31:0] wgt_data;
reg nxt_out_vld;

// Implicit weight replication for a single vector pair
always @* begin
    wgt_data = IND_DATA;
    if (implicit_two && mb_kind == `AMPP_KIND_L0) begin
        wgt_data = {w_lo, w_lo};
    end else if (implicit_two && mb_kind == `AMPP_KIND_L1) begin
        wgt_data = {w_hi, w_hi};
    end
end

// Format errors from inline word 0 and bad coefficient records
always @* begin
    err_set = 2'h0;
    if (mb_start && fmt_bad(inl0_ff)) begin
        err_set[`AMPP_ST_FMT] = 1'b1;
    end
    if (coef_take && (IND_DATA[`AMPP_CRSV_HI:`AMPP_CRSV_LO] != 9'h000)) begin
        err_set[`AMPP_ST_COEF] = 1'b1;
    end
    if (coef_take && blk_ff == `AMPP_BLK_DONE) begin
        err_set[`AMPP_ST_COEF] = 1'b1;
    end
end

// Output slot for indirect data
always @* begin
    nxt_out_vld = OUT_VALID & ~OUT_READY;
    if (ind_take) begin
        nxt_out_vld = 1'b1;
    end
end

// Output registers and decoded coefficient fields
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        OUT_VALID <= 1'b0;
        OUT_WEIGHT <= 1'b0;
        OUT_DATA <= 32'h00000000;
        COEF_VALUE <= 16'h0000;
        COEF_INDEX <= 6'h00;
        COEF_LAST <= 1'b0;
        COEF_BLOCK <= 3'h0;
        COEF_SUB <= 2'h0;
        IND_READY <= 1'b0;
    end else begin
        OUT_VALID <= nxt_out_vld;
        IND_READY <= en & ~nxt_out_vld & out_free;
        if (ind_take) begin
            OUT_WEIGHT <= IND_WEIGHT;
            OUT_DATA <= IND_WEIGHT ? wgt_data : IND_DATA;
            COEF_VALUE <= IND_DATA[`AMPP_CVAL_HI:`AMPP_CVAL_LO];
            COEF_INDEX <= IND_DATA[`AMPP_CIDX_HI:`AMPP_CIDX_LO];
            COEF_LAST <= IND_DATA[`AMPP_CLAST] & ~IND_WEIGHT;
            COEF_BLOCK <= blk_ff;
            COEF_SUB <= sub_ff;
        end
    end
end

// Block and subblock sequencer over present blocks
always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
        pres_ff <= 6'h00;
        blk_ff <= `AMPP_BLK_DONE;
        sub_ff <= 2'h0;
        ccnt_ff <= 16'h0000;
    end else if (mb_start) begin
        pres_ff <= pres_new;
        blk_ff <= next_blk(pres_new, 3'h0);
        sub_ff <= 2'h0;
        ccnt_ff <= 16'h0000;
    end else if (coef_take) begin
        ccnt_ff <= ccnt_ff + 16'h0001;
        if (IND_DATA[`AMPP_CLAST] && blk_ff != `AMPP_BLK_DONE) begin
            if (sub_ff == sub_top) begin
                sub_ff <= 2'h0;
                blk_ff <= next_blk(pres_ff, blk_ff + 3'h1);
            end else begin
                sub_ff <= sub_ff + 2'h1;
            end
        end
    end
end

endmodule // ampp_parser
`default_nettype wire

//--- tb/ampp_parser_props.sv
// Assertion checker for the macroblock payload parser
`timescale 1ns/1ps
`default_nettype none
module ampp_parser_props (
    input wire CLK,
    input wire NRST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_ACK_O,
    input wire CMD_VALID,
    input wire [31:0] CMD_DATA,
    input wire CMD_LAST,
    input wire CMD_READY,
    input wire PAY_VALID,
    input wire [31:0] PAY_DATA,
    input wire PAY_LAST,
    input wire PAY_READY,
    input wire OUT_VALID,
    input wire OUT_WEIGHT,
    input wire [31:0] OUT_DATA,
    input wire [15:0] COEF_VALUE,
    input wire [5:0] COEF_INDEX,
    input wire COEF_LAST,
    input wire OUT_READY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    reg [7:0] word_ff;
    reg [2:0] pay_ff;
    wire take = CMD_VALID && CMD_READY;
    wire coef = OUT_VALID && !OUT_WEIGHT;
    // Word position in command, payload words mod 8
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            word_ff <= 8'h00;
            pay_ff <= 3'h0;
        end else begin
            if (take)
                word_ff <= CMD_LAST ? 8'h00 : word_ff + 8'h01;
            if (PAY_VALID && PAY_READY)
                pay_ff <= pay_ff + 3'h1;
        end
    end
    // ----
    // Properties
    // ----
    sequence s_wb_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_ack_pulse;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence
    property p_wb_ack; s_wb_req |=> s_ack_pulse; endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("ack not one cycle");
    property p_pay_hold; PAY_VALID && !PAY_READY |=> PAY_VALID && $stable(PAY_DATA); endproperty
    a_pay_hold: assert property (p_pay_hold) else $error("payload dropped");
    property p_out_hold; OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA); endproperty
    a_out_hold: assert property (p_out_hold) else $error("output dropped");
    property p_coef_val; coef |-> COEF_VALUE == OUT_DATA[31:16]; endproperty
    a_coef_val: assert property (p_coef_val) else $error("value field");
    property p_coef_idx; coef |-> COEF_INDEX == OUT_DATA[6:1]; endproperty
    a_coef_idx: assert property (p_coef_idx) else $error("index field");
    property p_coef_last; coef |-> COEF_LAST == OUT_DATA[0]; endproperty
    a_coef_last: assert property (p_coef_last) else $error("last flag");
    property p_inline; take && word_ff >= 8'h04 && word_ff <= 8'h06
        |=> PAY_VALID && PAY_DATA == $past(CMD_DATA); endproperty
    a_inline: assert property (p_inline) else $error("inline not forwarded");
    property p_hdr; take && word_ff < 8'h04 && !PAY_VALID |=> !PAY_VALID; endproperty
    a_hdr: assert property (p_hdr) else $error("header forwarded");
    property p_pay_last; PAY_VALID && PAY_LAST |-> pay_ff == 3'h7; endproperty
    a_pay_last: assert property (p_pay_last) else $error("last off boundary");
endmodule // ampp_parser_props
bind ampp_parser ampp_parser_props i_props (
    .CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .CMD_VALID(CMD_VALID), .CMD_DATA(CMD_DATA),
    .CMD_LAST(CMD_LAST), .CMD_READY(CMD_READY), .PAY_VALID(PAY_VALID),
    .PAY_DATA(PAY_DATA), .PAY_LAST(PAY_LAST), .PAY_READY(PAY_READY),
    .OUT_VALID(OUT_VALID), .OUT_WEIGHT(OUT_WEIGHT), .OUT_DATA(OUT_DATA),
    .COEF_VALUE(COEF_VALUE), .COEF_INDEX(COEF_INDEX), .COEF_LAST(COEF_LAST),
    .OUT_READY(OUT_READY));
`default_nettype wire

//--- tb/ampp_sink.sv
// Thread payload and output sink with optional stalls
`timescale 1ns/1ps
`default_nettype none
module ampp_sink (
    input wire logic clk,
    input wire logic nrst,
    input wire logic slow,
    output logic pay_ready,
    output logic out_ready
);
    reg [1:0] tick_ff;
    // Ready every cycle, or one cycle in four when slow
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_ff <= 2'h0;
            pay_ready <= 1'b0;
            out_ready <= 1'b0;
        end else begin
            tick_ff <= tick_ff + 2'h1;
            pay_ready <= !slow || tick_ff == 2'h0;
            out_ready <= !slow || tick_ff == 2'h2;
        end
    end
endmodule // ampp_sink
`default_nettype wire

//--- tb/ampp_parser_bench.sv
// Self-checking bench for the macroblock payload parser
`timescale 1ns/1ps
`include "ampp_map.vh"
`default_nettype none
module ampp_parser_bench;
    logic clk, nrst, cyc, stb, we, cv, cl, iv, iw, slow, ack, cr, pv, pl, pr, ir, ov, ow, orr;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] wdat, cd, id, rdat, pd, od, lfsr, q, org;
    logic [2:0] cblk;
    logic [1:0] csub;
    logic [32:0] pay_q[$];
    logic [37:0] out_q[$];
    logic [31:0] bad[6] = '{32'h0200_0004, 32'h0100_0004, 32'h0020_2004,
        32'h0000_0008, 32'h0000_0003, 32'h0000_00C4};
    int fails, num_checks, kind, k;
    ampp_parser i_dut (.CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .CMD_VALID(cv), .CMD_DATA(cd), .CMD_LAST(cl), .CMD_READY(cr),
        .PAY_VALID(pv), .PAY_DATA(pd), .PAY_LAST(pl), .PAY_READY(pr), .IND_VALID(iv),
        .IND_DATA(id), .IND_WEIGHT(iw), .IND_READY(ir), .OUT_VALID(ov), .OUT_WEIGHT(ow),
        .OUT_DATA(od), .COEF_VALUE(), .COEF_INDEX(), .COEF_LAST(), .COEF_BLOCK(cblk),
        .COEF_SUB(csub), .OUT_READY(orr));
    ampp_sink i_sink (.clk(clk), .nrst(nrst), .slow(slow), .pay_ready(pr), .out_ready(orr));
    // Clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic cmp_reg(input [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: register %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_pay(input [32:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: payload %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_out(input [37:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: output %h expected %h", $time, got, exp);
        end
    endtask
    // ----
    // Bus and stream drivers
    // ----
    // Classic cycle: hold until ack is seen high at a rising edge, only the watchdog ends it
    task automatic wb(input w, input [7:0] a, input [31:0] d, output [31:0] r);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        r = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic push(input bit ind, input [31:0] d, input f);
        int n;
        @(posedge clk);
        if (ind)
            {iv, id, iw} <= {1'b1, d, f};
        else
            {cv, cd, cl} <= {1'b1, d, f};
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((ind ? ir : cr) !== 1'b1 && n < 200);
        @(posedge clk);
        iv <= 1'b0;
        cv <= 1'b0;
    endtask
    task automatic drain();
        int n;
        n = 0;
        while (pay_q.size() + out_q.size() > 0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask
    // One macroblock command, expected payload queued first
    task automatic mb(input [31:0] w0, input [5:0] pres, input int extra, input bit mc);
        logic [31:0] w[$];
        int j, n, t;
        w.push_back(w0);
        w.push_back(rnd());
        org = w[1];
        w.push_back({18'h0, pres, 8'(rnd())});
        for (j = 0; j < extra; j++)
            w.push_back(rnd());
        n = mc ? w.size() : 3;
        t = (n + 7) / 8 * 8;
        for (j = 0; j < t; j++)
            pay_q.push_back({j == t - 1, j < n ? w[j] : 32'h0});
        for (j = 0; j < 4; j++)
            push(0, rnd(), 0);
        for (j = 0; j < w.size(); j++)
            push(0, w[j], j == w.size() - 1);
    endtask
    // Implicit weights, then luma 0 (two records) and red chroma subblocks
    task automatic ind(input [4:0] kd);
        logic [31:0] v;
        int j;
        for (j = 0; j < 4; j++) begin
            v = j == 3 ? 32'h0 : rnd();
            out_q.push_back({1'b1, kd == 5'h01 ? {2{v[15:0]}} :
                kd == 5'h02 ? {2{v[31:16]}} : v, 5'h00});
            push(1, v, 1);
        end
        for (j = 0; j < 6; j++) begin
            v = rnd();
            v = {v[31:16], 9'h000, v[6:1], j != 0};
            out_q.push_back({1'b0, v, j < 2 ? 3'h0 : 3'h5, j < 2 ? 2'h0 : 2'(j - 2)});
            push(1, v, 0);
        end
    endtask
    // Output monitor takes the oldest expectation
    always @(posedge clk) begin
        if (pv && pr)
            cmp_pay({pl, pd}, pay_q.size() ? pay_q.pop_front() : 'x);
        if (ov && orr)
            cmp_out({ow, od, ow ? 5'h0 : {cblk, csub}},
                out_q.size() ? out_q.pop_front() : 'x);
    end
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {nrst, cyc, stb, we, cv, cl, iv, iw, slow} = '0;
        {adr, wdat, cd, id} = '0;
        sel = 4'hF;
        lfsr = 32'h0000_004A;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        wb(0, `AMPP_OFS_CTRL, 0, q);
        cmp_reg(q, 32'h3);
        wb(0, 8'h40, 0, q);
        cmp_reg(q, 32'h0);
        for (kind = 1; kind <= 3; kind++) begin
            slow <= kind == 2;
            mb(32'h0020_8084 | (kind << 8), 6'b100001, kind * 3, 1);
            ind(kind[4:0]);
            drain();
            wb(0, `AMPP_OFS_FLAGS, 0, q);
            cmp_reg(q, 32'h0020_8084 | (kind << 8));
            wb(0, `AMPP_OFS_COUNT, 0, q);
            cmp_reg(q, 32'h6);
            wb(0, `AMPP_OFS_ORIGIN, 0, q);
            cmp_reg(q, {16'h0, org[15:0]});
            wb(0, `AMPP_OFS_PATTERN, 0, q);
            cmp_reg(q, 32'h21);
            wb(0, `AMPP_OFS_STATUS, 0, q);
            cmp_reg(q & 32'h3, 32'h0);
        end
        wb(1, `AMPP_OFS_CTRL, 32'h1, q);
        mb(32'h0000_8004, 6'h00, 4, 0);
        drain();
        wb(1, `AMPP_OFS_CTRL, 32'h3, q);
        for (k = 0; k < 6; k++) begin
            mb(bad[k], 6'h00, 0, 1);
            drain();
            wb(0, `AMPP_OFS_STATUS, 0, q);
            cmp_reg(q & 32'h1, 32'h1);
            wb(1, `AMPP_OFS_STATUS, 32'h1, q);
        end
        wb(0, `AMPP_OFS_STATUS, 0, q);
        cmp_reg(q & 32'h1, 32'h0);
        cmp_reg(pay_q.size() + out_q.size(), 32'h0);
        tally_and_finish();
    end
endmodule // ampp_parser_bench
`default_nettype wire
